/* File: hw/mread_cfg.svh */
/*
 * Constants for the multi-read command engine: identifiers, entry layout,
 * status codes and timing. Assumes inclusion by bare name from hw/.
 */
`ifndef MREAD_CFG_SVH
`define MREAD_CFG_SVH

// command and acknowledge identifiers, acknowledges have bit 0 set
`define ID_MREAD_CMD      16'h0806
`define ID_MREAD_ACK      16'h0807
`define ID_DEFER_ACK      16'h0805

// multi-read entry layout, byte offsets within one entry
`define ENT_BYTES         4'h c
`define ENT_ADDR_OFS      0
`define ENT_RSVD_OFS      8
`define ENT_LEN_OFS       10

// deferral acknowledge payload layout, byte offsets
`define DEFER_RSVD_OFS    0
`define DEFER_TMO_OFS     2

// acknowledge status codes
`define ST_OK             16'h0000
`define ST_BAD_PARAM      16'h8003
`define ST_READ_FAIL      16'h8006

// timing: one millisecond tick at a 10 ns clock
`define TICK_MS           1
`define CLK_PERIOD_NS     10
`define CLKS_PER_MS       ((`TICK_MS * 1000000) / `CLK_PERIOD_NS)

`endif

/* File: hw/mread_pkg.sv */
/*
 * Types shared by the multi-read engine.
 * Assumes hw/mread_cfg.svh supplies all numeric constants.
 */
package mread_pkg;
	typedef enum logic [2:0] {
		S_IDLE,
		S_ENTRY,
		S_READ,
		S_SEND,
		S_DRAIN,
		S_FINISH
	} eng_state_t;

	typedef logic [15:0] status_t;
endpackage : mread_pkg

/* File: hw/entry_parser.sv */
/*
 * Splits a multi-read payload byte stream into 12-byte entries.
 * Assumes bytes arrive little endian and the payload length comes from the
 * common command header, sampled on start.
 */
`include "mread_cfg.svh"

module entry_parser #(
	parameter int LEN_W = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             start,
	input  wire logic [LEN_W-1:0] total_len,
	input  wire logic             pay_valid,
	input  wire logic [7:0]       pay_data,
	input  wire logic             ent_take,
	output logic                  pay_ready,
	output logic                  ent_valid,
	output logic [63:0]           ent_addr,
	output logic [15:0]           ent_len,
	output logic                  parse_done,
	output logic                  tail_bad
);
	logic [LEN_W-1:0] remain, next_remain;
	logic [3:0]       idx, next_idx;
	logic [95:0]      sh, next_sh;
	logic             active, next_active;
	logic             next_pay_ready, next_ent_valid, next_parse_done, next_tail_bad;
	logic [63:0]      next_ent_addr;
	logic [15:0]      next_ent_len;

	// entry assembly; the entry count falls out of the sender's length
	always_comb begin
		next_remain     = remain;
		next_idx        = idx;
		next_sh         = sh;
		next_active     = active;
		next_ent_valid  = ent_valid;
		next_ent_addr   = ent_addr;
		next_ent_len    = ent_len;
		next_parse_done = parse_done;
		next_tail_bad   = tail_bad;
		if (start) begin
			next_remain     = total_len; // RQ8
			next_idx        = 4'h0;
			next_active     = 1'b1;
			next_ent_valid  = 1'b0;
			next_parse_done = 1'b0;
			next_tail_bad   = 1'b0;
		end else begin
			if (ent_take)
				next_ent_valid = 1'b0;
			if (pay_valid && pay_ready) begin
				next_sh     = {pay_data, sh[95:8]};
				next_remain = remain - 1'b1;
				if (idx == `ENT_BYTES - 4'h1) begin
					next_idx       = 4'h0;
					next_ent_valid = 1'b1;
					next_ent_addr  = next_sh[8*`ENT_ADDR_OFS +: 64]; // RQ7
					next_ent_len   = next_sh[8*`ENT_LEN_OFS +: 16]; // RQ7
				end else begin
					next_idx = idx + 4'h1;
				end
			end
			// a short trailing fragment is flagged, not executed
			if (active && next_remain == '0 && !next_ent_valid) begin
				next_active     = 1'b0;
				next_parse_done = 1'b1; // RQ8
				next_tail_bad   = (next_idx != 4'h0);
			end
		end
		next_pay_ready = next_active && !next_ent_valid && next_remain != '0;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			remain     <= '0;
			idx        <= 4'h0;
			sh         <= '0;
			active     <= 1'b0;
			pay_ready  <= 1'b0;
			ent_valid  <= 1'b0;
			ent_addr   <= '0;
			ent_len    <= '0;
			parse_done <= 1'b0;
			tail_bad   <= 1'b0;
		end else begin
			remain     <= next_remain;
			idx        <= next_idx;
			sh         <= next_sh;
			active     <= next_active;
			pay_ready  <= next_pay_ready;
			ent_valid  <= next_ent_valid;
			ent_addr   <= next_ent_addr;
			ent_len    <= next_ent_len;
			parse_done <= next_parse_done;
			tail_bad   <= next_tail_bad;
		end
	end
endmodule : entry_parser

/* File: hw/mread_engine.sv */
/*
 * Multi-read command engine with deferral acknowledges.
 * Assumes a framer upstream that strips prefix and header, supplying id, tag
 * and payload length, and a framer downstream that builds the acknowledge
 * header from the done group and the streamed data bytes.
 */
`include "mread_cfg.svh"

// Overview of operation
// RQ1 - when execution outlasts the response limit, send a deferral carrying the tag
// RQ2 - host applies the new timeout only to the matching tag
// RQ3 - deferrals may repeat; each one re-arms the command's timeout
// RQ4 - host times from the deferral, not from the original command
// RQ5 - deferral payload: two zero bytes, then two-byte timeout
// RQ6 - timeout is an unsigned millisecond count
// RQ7 - each entry: 64-bit address, zero reserved half, 16-bit count
// RQ8 - entry count comes from parsing up to the sender's packet length
// RQ9 - host keeps total requested read bytes within the packet limit
// RQ10 - addresses and counts are byte aligned
// RQ11 - read data returned back to back in request order
// RQ12 - short read total gives a status naming the cause
// RQ13 - after a failed entry, later entries are not executed
// RQ14 - only bytes read before the failure are returned
// RQ15 - acknowledge identifiers have bit 0 set, commands cleared
// RQ16 - after deferrals the normal acknowledge still follows with the same tag
module mread_engine #(
	parameter int CYCLES_PER_MS = `CLKS_PER_MS
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        cmd_start,
	input  wire logic [15:0] cmd_id,
	input  wire logic [15:0] cmd_tag,
	input  wire logic [15:0] cmd_len,
	input  wire logic        pay_valid,
	input  wire logic [7:0]  pay_data,
	output logic             pay_ready,
	input  wire logic [15:0] max_response_time_limit,
	input  wire logic [15:0] defer_timeout_ms,
	output logic             mem_req,
	output logic [63:0]      mem_addr,
	input  wire logic        mem_ack,
	input  wire logic        mem_err,
	input  wire logic [15:0] mem_err_code,
	input  wire logic [7:0]  mem_rdata,
	output logic             ack_valid,
	output logic [7:0]       ack_data,
	input  wire logic        ack_ready,
	output logic             done_valid,
	output logic [15:0]      done_id,
	output logic [15:0]      done_tag,
	output logic [15:0]      done_status,
	output logic [15:0]      done_len,
	output logic             defer_valid,
	output logic [15:0]      defer_id,
	output logic [15:0]      defer_tag,
	output logic [31:0]      defer_payload,
	output logic             busy
);
	mread_pkg::eng_state_t state, next_state;
	mread_pkg::status_t    status, next_status;
	logic [15:0] tag, next_tag, rem, next_rem, total, next_total;
	logic [63:0] next_mem_addr;
	logic        next_mem_req, next_ack_valid, next_done_valid, next_busy;
	logic [7:0]  next_ack_data;
	logic        ent_take, ent_valid, parse_done, tail_bad, start_ok;
	logic [63:0] ent_addr;
	logic [15:0] ent_len;
	logic [31:0] cyc, next_cyc;
	logic [15:0] ms, next_ms, window, next_window;
	logic        next_defer_valid;
	logic [15:0] next_defer_tag;
	logic [31:0] next_defer_payload;
	logic [15:0] sent_cnt;

	// bit 0 separates commands from acknowledges
	function automatic logic is_command(input logic [15:0] id);
		return !id[0];
	endfunction : is_command

	assign start_ok = cmd_start && state == mread_pkg::S_IDLE && is_command(cmd_id) // RQ15
		&& cmd_id == `ID_MREAD_CMD;
	assign ent_take = ent_valid && (state == mread_pkg::S_ENTRY || state == mread_pkg::S_DRAIN);

	entry_parser #(
		.LEN_W(16)
	) parser (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.start      (start_ok),
		.total_len  (cmd_len),
		.pay_valid  (pay_valid),
		.pay_data   (pay_data),
		.ent_take   (ent_take),
		.pay_ready  (pay_ready),
		.ent_valid  (ent_valid),
		.ent_addr   (ent_addr),
		.ent_len    (ent_len),
		.parse_done (parse_done),
		.tail_bad   (tail_bad)
	);

	// command sequencing; one byte read in flight keeps back-pressure simple
	always_comb begin
		next_state      = state;
		next_status     = status;
		next_tag        = tag;
		next_rem        = rem;
		next_total      = total;
		next_mem_req    = mem_req;
		next_mem_addr   = mem_addr;
		next_ack_valid  = ack_valid;
		next_ack_data   = ack_data;
		next_done_valid = 1'b0;
		case (state)
			mread_pkg::S_IDLE: begin
				if (start_ok) begin
					next_tag    = cmd_tag;
					next_status = `ST_OK;
					next_total  = 16'h0000;
					next_state  = mread_pkg::S_ENTRY;
				end
			end
			mread_pkg::S_ENTRY: begin
				if (ent_valid) begin
					next_mem_addr = ent_addr; // RQ10
					next_rem      = ent_len;
					if (ent_len != 16'h0000) begin
						next_mem_req = 1'b1;
						next_state   = mread_pkg::S_READ;
					end
				end else if (parse_done) begin
					if (tail_bad)
						next_status = `ST_BAD_PARAM; // RQ12
					next_state = mread_pkg::S_FINISH;
				end
			end
			mread_pkg::S_READ: begin
				if (mem_err) begin
					next_mem_req = 1'b0;
					next_status  = (mem_err_code != `ST_OK) ? mem_err_code : `ST_READ_FAIL; // RQ12
					next_state   = mread_pkg::S_DRAIN; // RQ13
				end else if (mem_ack) begin
					next_mem_req   = 1'b0;
					next_ack_data  = mem_rdata;
					next_ack_valid = 1'b1;
					next_mem_addr  = mem_addr + 64'h0000_0000_0000_0001; // RQ11
					next_rem       = rem - 16'h0001;
					next_state     = mread_pkg::S_SEND;
				end
			end
			mread_pkg::S_SEND: begin
				if (ack_ready) begin
					next_ack_valid = 1'b0;
					next_total     = total + 16'h0001; // RQ14
					if (rem == 16'h0000)
						next_state = mread_pkg::S_ENTRY;
					else begin
						next_mem_req = 1'b1;
						next_state   = mread_pkg::S_READ;
					end
				end
			end
			mread_pkg::S_DRAIN: begin
				// remaining entries are swallowed unexecuted
				if (!ent_valid && parse_done)
					next_state = mread_pkg::S_FINISH; // RQ13
			end
			mread_pkg::S_FINISH: begin
				next_done_valid = 1'b1; // RQ16
				next_state      = mread_pkg::S_IDLE;
			end
			default: next_state = mread_pkg::S_IDLE;
		endcase
		next_busy = next_state != mread_pkg::S_IDLE;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state       <= mread_pkg::S_IDLE;
			status      <= `ST_OK;
			tag         <= 16'h0000;
			rem         <= 16'h0000;
			total       <= 16'h0000;
			mem_req     <= 1'b0;
			mem_addr    <= 64'h0000_0000_0000_0000;
			ack_valid   <= 1'b0;
			ack_data    <= 8'h00;
			done_valid  <= 1'b0;
			done_status <= `ST_OK;
			done_len    <= 16'h0000;
			done_tag    <= 16'h0000;
			busy        <= 1'b0;
			done_id     <= `ID_MREAD_ACK; // RQ15
			defer_id    <= `ID_DEFER_ACK; // RQ15
		end else begin
			state       <= next_state;
			status      <= next_status;
			tag         <= next_tag;
			rem         <= next_rem;
			total       <= next_total;
			mem_req     <= next_mem_req;
			mem_addr    <= next_mem_addr;
			ack_valid   <= next_ack_valid;
			ack_data    <= next_ack_data;
			done_valid  <= next_done_valid;
			done_status <= next_status;
			done_len    <= next_total;
			done_tag    <= next_tag;
			busy        <= next_busy;
			done_id     <= `ID_MREAD_ACK; // RQ15
			defer_id    <= `ID_DEFER_ACK; // RQ15
		end
	end

	// millisecond timer; a deferral goes out one tick before the window ends,
	// so the host's timer is re-armed before it can fire
	always_comb begin
		next_cyc           = cyc;
		next_ms            = ms;
		next_window        = window;
		next_defer_valid   = 1'b0;
		next_defer_tag     = defer_tag;
		next_defer_payload = defer_payload;
		if (start_ok) begin
			next_cyc    = 32'h0000_0000;
			next_ms     = 16'h0000;
			next_window = max_response_time_limit;
		end else if (busy && state != mread_pkg::S_FINISH) begin
			if (cyc == 32'(CYCLES_PER_MS - 1)) begin
				next_cyc = 32'h0000_0000;
				next_ms  = ms + 16'h0001;
				if (next_ms >= window - 16'h0001 && window != 16'h0000) begin
					next_defer_valid   = 1'b1; // RQ1
					next_defer_tag     = tag; // RQ1
					next_defer_payload = {defer_timeout_ms, 16'h0000}; // RQ5 RQ6
					next_ms            = 16'h0000; // RQ3
					next_window        = defer_timeout_ms; // RQ3
				end
			end else begin
				next_cyc = cyc + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cyc           <= 32'h0000_0000;
			ms            <= 16'h0000;
			window        <= 16'h0000;
			defer_valid   <= 1'b0;
			defer_tag     <= 16'h0000;
			defer_payload <= 32'h0000_0000;
		end else begin
			cyc           <= next_cyc;
			ms            <= next_ms;
			window        <= next_window;
			defer_valid   <= next_defer_valid;
			defer_tag     <= next_defer_tag;
			defer_payload <= next_defer_payload;
		end
	end

	// helper: data bytes handed over during the current command
	always_ff @(posedge ref_clk) begin
		if (rst || start_ok)
			sent_cnt <= 16'h0000;
		else if (ack_valid && ack_ready)
			sent_cnt <= sent_cnt + 16'h0001;
	end

	a_defer_fields: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
		defer_valid |-> defer_payload == {$past(defer_timeout_ms), 16'h0000} && defer_id[0])
		else $error("bad deferral payload");
	a_defer_tag: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
		defer_valid |-> defer_tag == tag && busy) else $error("deferral tag mismatch");
	a_done_ident: assert property (@(posedge ref_clk) disable iff (rst) // RQ16
		done_valid |-> done_id[0] && done_tag == tag && !busy) else $error("bad final acknowledge");
	a_fail_status: assert property (@(posedge ref_clk) disable iff (rst) // RQ12
		(state == mread_pkg::S_READ && mem_err) |=> state == mread_pkg::S_DRAIN && status != `ST_OK)
		else $error("read failure not reported");
	a_no_late_read: assert property (@(posedge ref_clk) disable iff (rst) // RQ13
		state == mread_pkg::S_DRAIN |-> !mem_req && !ack_valid) else $error("read after failure");
	a_data_count: assert property (@(posedge ref_clk) disable iff (rst) // RQ14
		done_valid |-> done_len == sent_cnt) else $error("returned length wrong");
	a_addr_step: assert property (@(posedge ref_clk) disable iff (rst) // RQ11
		(state == mread_pkg::S_READ && mem_ack && !mem_err) |=> mem_addr == $past(mem_addr) + 64'h1 && ack_valid)
		else $error("address not advanced");
	a_ack_hold: assert property (@(posedge ref_clk) disable iff (rst) // RQ11
		(ack_valid && !ack_ready) |=> ack_valid && $stable(ack_data)) else $error("data byte dropped");
	a_defer_rearm: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
		defer_valid |-> ms == 16'h0000 ##1 !defer_valid) else $error("deferral not re-armed");
endmodule : mread_engine

/* File: testbench/mem_model.sv */
/*
 * Behavioural register-map responder for the engine's byte read port.
 * Assumes one outstanding read at a time, outputs driven on falling edges.
 */
module mem_model (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        mem_req,
	input  wire logic [63:0] mem_addr,
	input  wire logic        slow,
	input  wire logic [63:0] fail_addr,
	input  wire logic [15:0] fail_code,
	output logic             mem_ack = 1'b0,
	output logic             mem_err = 1'b0,
	output logic [15:0]      mem_err_code = 16'h0000,
	output logic [7:0]       mem_rdata = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	int   wait_cnt = 0;
	logic answered = 1'b0;

	// one answer per request; released data toggles so stale bytes never match
	always @(negedge ref_clk) begin
		mem_ack <= 1'b0;
		mem_err <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (rst || !mem_req) begin
			wait_cnt <= 0;
			answered <= 1'b0;
		end else if (!answered) begin
			if (wait_cnt < (slow ? 3 : 0)) begin
				wait_cnt <= wait_cnt + 1;
			end else begin
				answered <= 1'b1;
				if (mem_addr === fail_addr) begin
					mem_err <= 1'b1;
					mem_err_code <= fail_code;
				end else begin
					mem_ack <= 1'b1;
					mem_rdata <= mem_addr[7:0] ^ 8'ha5;
				end
			end
		end
	end
endmodule : mem_model

/* File: testbench/stacked_read_and_deferral_ack_bench.sv */
/*
 * Self-checking bench for the multi-read engine, acting as the host.
 * Assumes hw/ on the include path and a 100 MHz clock.
 */
`include "mread_cfg.svh"

module stacked_read_and_deferral_ack_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CPM = 4;
	localparam int MAX_READ = 1024; // link packet limit, plain default
	logic ref_clk = 1'b0, rst = 1'b1, cmd_start = 1'b0, pay_valid = 1'b0, ack_ready = 1'b0, slow = 1'b0;
	logic [15:0] cmd_id = 16'h0000, cmd_tag = 16'h0000, cmd_len = 16'h0000, limit = 16'h0000, tmo = 16'h0000;
	logic [7:0] pay_data = 8'h00;
	logic [63:0] fail_addr = 64'hffff_ffff_ffff_ffff;
	logic [15:0] fail_code = 16'h0000;
	logic pay_ready, mem_req, mem_ack, mem_err, ack_valid, done_valid, defer_valid, busy;
	logic [63:0] mem_addr;
	logic [15:0] mem_err_code, done_id, done_tag, done_status, done_len, defer_id, defer_tag;
	logic [7:0] mem_rdata, ack_data;
	logic [31:0] defer_payload;
	logic [7:0] pay[$], got[$], exp_q[$];
	logic [63:0] reads[$];
	logic [15:0] d_status, d_len, d_tag, d_id;
	int failures = 0, tests_run = 0, cyc = 0, defers, deadline;
	logic done, stall;

	mread_engine #(.CYCLES_PER_MS(CPM)) u_mread_engine (.ref_clk(ref_clk), .rst(rst), .cmd_start(cmd_start),
		.cmd_id(cmd_id), .cmd_tag(cmd_tag), .cmd_len(cmd_len), .pay_valid(pay_valid), .pay_data(pay_data),
		.pay_ready(pay_ready), .max_response_time_limit(limit), .defer_timeout_ms(tmo), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_err(mem_err), .mem_err_code(mem_err_code),
		.mem_rdata(mem_rdata), .ack_valid(ack_valid), .ack_data(ack_data), .ack_ready(ack_ready),
		.done_valid(done_valid), .done_id(done_id), .done_tag(done_tag), .done_status(done_status),
		.done_len(done_len), .defer_valid(defer_valid), .defer_id(defer_id), .defer_tag(defer_tag),
		.defer_payload(defer_payload), .busy(busy));
	mem_model u_mem_model (.ref_clk(ref_clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr), .slow(slow),
		.fail_addr(fail_addr), .fail_code(fail_code), .mem_ack(mem_ack), .mem_err(mem_err),
		.mem_err_code(mem_err_code),
		.mem_rdata(mem_rdata));

	// clock and hang guard, ceiling well above the few hundred cycles needed
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			finish_test();
		end
	end

	task automatic check(string what, logic [63:0] exp, logic [63:0] seen);
		tests_run++;
		if (exp !== seen) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// entry fields go little endian, reserved half zero
	task automatic add_entry(logic [63:0] a, logic [15:0] n);
		logic [63:0] x;
		for (int i = 0; i < 8; i++) pay.push_back(a[8*i+:8]);
		pay.push_back(8'h00);
		pay.push_back(8'h00);
		pay.push_back(n[7:0]);
		pay.push_back(n[15:8]);
		for (int i = 0; i < n; i++) begin
			x = a + 64'(i);
			exp_q.push_back(x[7:0] ^ 8'ha5);
		end
	endtask : add_entry

	// host side: feed payload, collect data, track the per-tag deadline
	task automatic run(logic [15:0] tag);
		@(negedge ref_clk);
		cmd_start = 1'b1;
		cmd_id = `ID_MREAD_CMD;
		cmd_tag = tag;
		cmd_len = 16'(pay.size());
		check("read_total", 1, exp_q.size() <= MAX_READ);
		got.delete();
		reads.delete();
		defers = 0;
		done = 1'b0;
		deadline = (limit == 0) ? 1000000 : cyc + limit * CPM + 2;
		@(negedge ref_clk);
		cmd_start = 1'b0;
		fork
			begin
				while (pay.size() > 0 && !done) begin
					pay_valid = 1'b1;
					pay_data = pay[0];
					@(posedge ref_clk);
					if (pay_ready === 1'b1) void'(pay.pop_front());
					@(negedge ref_clk);
				end
				pay_valid = 1'b0;
			end
			begin
				while (!done) begin
					@(posedge ref_clk);
					if (ack_valid && ack_ready) got.push_back(ack_data);
					if (mem_req && (mem_ack || mem_err)) reads.push_back(mem_addr);
					if (defer_valid === 1'b1) begin
						defers++;
						check("defer_tag", tag, defer_tag);
						check("defer_payload", {tmo, 16'h0000}, defer_payload);
						check("defer_id_lsb", 1, defer_id[0]);
						check("defer_in_time", 1, cyc <= deadline);
						deadline = cyc + tmo * CPM + 2;
					end
					if (done_valid === 1'b1) begin
						done = 1'b1;
						{d_status, d_len, d_tag, d_id} = {done_status, done_len, done_tag, done_id};
						check("done_in_time", 1, cyc <= deadline);
					end
				end
			end
			begin
				while (!done) begin
					@(negedge ref_clk);
					ack_ready = !stall || cyc[1];
				end
			end
		join
		check("done_tag", tag, d_tag);
		check("done_id", `ID_MREAD_ACK, d_id);
		check("byte_count", exp_q.size(), got.size());
		for (int i = 0; i < exp_q.size() && i < got.size(); i++) check("ack_byte", exp_q[i], got[i]);
		exp_q.delete();
		pay.delete();
	endtask : run

	// two entries, no stall, back to back data
	task automatic t_two_entries();
		add_entry(64'h0000_0001_0000_00fe, 16'h0003);
		add_entry(64'h0000_0000_0000_2000, 16'h0002);
		run(16'h0011);
		check("status_ok", `ST_OK, d_status);
		check("len_ok", 5, d_len);
		check("no_defer", 0, defers);
	endtask : t_two_entries

	// zero-length entry plus slow memory and stalled data sink
	task automatic t_zero_stall();
		slow = 1'b1;
		stall = 1'b1;
		add_entry(64'h0000_0000_0000_0010, 16'h0000);
		add_entry(64'h0000_0000_0000_0020, 16'h0004);
		run(16'h0022);
		check("reads_zero", 4, reads.size());
		slow = 1'b0;
		stall = 1'b0;
	endtask : t_zero_stall

	// failure in second entry, third never read
	task automatic t_fail();
		fail_addr = 64'h0000_0000_0000_0081;
		add_entry(64'h0000_0000_0000_0040, 16'h0002);
		add_entry(64'h0000_0000_0000_0080, 16'h0001);
		pay.push_back(8'h00); // second entry asks for 3 bytes, only 1 succeeds
		void'(pay.pop_back());
		pay[pay.size()-2] = 8'h03;
		add_entry(64'h0000_0000_0000_0090, 16'h0000);
		pay[pay.size()-2] = 8'h02;
		run(16'h0033);
		check("status_fail", `ST_READ_FAIL, d_status);
		check("len_fail", 3, d_len);
		check("reads_fail", 4, reads.size());
		check("last_read", 64'h0000_0000_0000_0081, reads[reads.size()-1]);
		// a failure code from the memory side is passed through as the status
		fail_code = 16'h8010;
		add_entry(64'h0000_0000_0000_0080, 16'h0002);
		void'(exp_q.pop_back()); // byte at 0x81 fails
		run(16'h0036);
		check("status_code", 16'h8010, d_status);
		check("len_code", 1, d_len);
		fail_code = 16'h0000;
		fail_addr = 64'hffff_ffff_ffff_ffff;
	endtask : t_fail

	// trailing fragment shorter than an entry
	task automatic t_fragment();
		add_entry(64'h0000_0000_0000_0050, 16'h0001);
		for (int i = 0; i < 5; i++) pay.push_back(8'h77);
		run(16'h0044);
		check("status_frag", `ST_BAD_PARAM, d_status);
	endtask : t_fragment

	// long command with repeated deferrals
	task automatic t_defer();
		limit = 16'h0003;
		tmo = 16'h0002;
		slow = 1'b1;
		stall = 1'b1;
		add_entry(64'h0000_0000_0000_0300, 16'h0006);
		run(16'h0055);
		check("defer_repeat", 1, defers >= 2);
		check("status_defer", `ST_OK, d_status);
		{limit, tmo, slow, stall} = '0;
	endtask : t_defer

	// other identifiers are ignored
	task automatic t_refused();
		@(negedge ref_clk);
		cmd_start = 1'b1;
		cmd_id = 16'h0800;
		@(negedge ref_clk);
		cmd_start = 1'b0;
		@(negedge ref_clk);
		check("busy_refused", 0, busy);
	endtask : t_refused

	task automatic finish_test();
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	// main sequence
	initial begin
		stall = 1'b0;
		repeat (6) @(negedge ref_clk);
		rst = 1'b0;
		t_refused();
		t_two_entries();
		t_zero_stall();
		t_fail();
		t_fragment();
		t_defer();
		finish_test();
	end
endmodule : stacked_read_and_deferral_ack_bench
